// ==== rtl/tmf_pkg.sv ====
// package of constants and types, plus the two-entry output buffer
`default_nettype none
package tmf_pkg;
    // rates and channel layout
    localparam int SYSTEM_CLOCK_MHZ            = 10;
    localparam int PER_CHANNEL_SAMPLE_RATE_KHZ = 3300;
    localparam int KHZ_PER_MHZ                 = 1000;
    localparam int FOLD = (SYSTEM_CLOCK_MHZ * KHZ_PER_MHZ) / PER_CHANNEL_SAMPLE_RATE_KHZ;
    localparam int CHANNEL_TOTAL = 4;
    localparam int DECIM         = 2;
    localparam int DATA_W        = 8;
    localparam int RES_W         = DATA_W + 1;

    // wire counts round up so every channel finds a slot
    localparam int INPUT_WIRE_TOTAL        = (CHANNEL_TOTAL + FOLD - 1) / FOLD;
    localparam int CHANNELS_PER_INPUT_WIRE =
        (CHANNEL_TOTAL + INPUT_WIRE_TOTAL - 1) / INPUT_WIRE_TOTAL;
    localparam int OUT_SLOTS                = FOLD * DECIM;
    localparam int OUTPUT_WIRE_TOTAL        = (CHANNEL_TOTAL + OUT_SLOTS - 1) / OUT_SLOTS;
    localparam int CHANNELS_PER_OUTPUT_WIRE =
        (CHANNEL_TOTAL + OUTPUT_WIRE_TOTAL - 1) / OUTPUT_WIRE_TOTAL;
    localparam int IN_STORE  = INPUT_WIRE_TOTAL * CHANNELS_PER_INPUT_WIRE;
    localparam int OUT_STORE = OUTPUT_WIRE_TOTAL * CHANNELS_PER_OUTPUT_WIRE;
    localparam int STORE_DEPTH = (IN_STORE > OUT_STORE) ? IN_STORE : OUT_STORE;
    localparam int MAX_CPW = (CHANNELS_PER_INPUT_WIRE > CHANNELS_PER_OUTPUT_WIRE) ?
        CHANNELS_PER_INPUT_WIRE : CHANNELS_PER_OUTPUT_WIRE;
    localparam int CHAN_W = (MAX_CPW > 1) ? $clog2(MAX_CPW) : 1;

    // register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] FRAMES_ADDR = 8'h0C;
    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_FLUSH_BIT    = 1;
    localparam int STAT_ENABLE_BIT   = 0;
    localparam int STAT_BUSY_BIT     = 1;
    localparam int STAT_MISMATCH_BIT = 2;
    localparam int CFG_CHAN_LSB   = 0;
    localparam int CFG_IWIRE_LSB  = 8;
    localparam int CFG_OWIRE_LSB  = 12;
    localparam int CFG_CPI_LSB    = 16;
    localparam int CFG_CPO_LSB    = 20;
    localparam int CFG_FOLD_LSB   = 24;
    localparam int CFG_BYTE_W     = 8;
    localparam int CFG_NIB_W      = 4;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    typedef enum logic {SEQ_IDLE, SEQ_EMIT} tmf_seq_e;

    typedef struct packed {
        logic [CHAN_W-1:0]                         channel;
        logic [INPUT_WIRE_TOTAL-1:0][DATA_W-1:0]   data;
    } tmf_in_s;

    typedef struct packed {
        logic [CHAN_W-1:0]                         channel;
        logic [OUTPUT_WIRE_TOTAL-1:0][RES_W-1:0]   data;
    } tmf_out_s;
endpackage

// head register plus one spare, so a stalled receiver loses no word
module tmf_buf #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head_q, head_d, spare_q, spare_d;
    logic             hv_q, hv_d, sv_q, sv_d;

    always_comb begin
        head_d  = head_q;
        spare_d = spare_q;
        hv_d    = hv_q;
        sv_d    = sv_q;
        if (hv_q && out_ready) begin
            if (sv_q) begin
                head_d = spare_q;
                sv_d   = 1'b0;
            end else begin
                hv_d = 1'b0;
            end
        end
        if (in_valid && !sv_q) begin
            if (!hv_d) begin
                head_d = in_data;
                hv_d   = 1'b1;
            end else begin
                spare_d = in_data;
                sv_d    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_q  <= '0;
            spare_q <= '0;
            hv_q    <= 1'b0;
            sv_q    <= 1'b0;
        end else begin
            head_q  <= head_d;
            spare_q <= spare_d;
            hv_q    <= hv_d;
            sv_q    <= sv_d;
        end
    end

    assign in_ready  = !sv_q;
    assign out_valid = hv_q;
    assign out_data  = head_q;
endmodule
`default_nettype wire

// ==== rtl/tmf_sched.sv ====
// tdm multichannel scheduler: input serializer, per-wire datapaths, output deserializer
//
// Local design decisions: the placing of the registers and the APB register port.
`default_nettype none
module tmf_sched
    import tmf_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              in_valid,
    output var  logic              in_ready,
    input  wire tmf_in_s           in_word,
    output var  logic              out_valid,
    input  wire logic              out_ready,
    output var  tmf_out_s          out_word
);
    // register state
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        enable_q, enable_d;
    logic        flush_q, flush_d;
    logic        clr_mismatch;
    logic        wr_access;

    // stream state
    logic [CHAN_W-1:0] islot_q, islot_d;
    logic [CHAN_W-1:0] oslot_q, oslot_d;
    logic              keep_q, keep_d;
    tmf_seq_e          seq_q, seq_d;
    logic              in_ready_q, in_ready_d;
    logic              mismatch_q, mismatch_d;
    logic [31:0]       frames_q, frames_d;
    logic [DATA_W-1:0] hist_q [STORE_DEPTH];
    logic [DATA_W-1:0] hist_d [STORE_DEPTH];
    logic [RES_W-1:0]  res_q  [STORE_DEPTH];
    logic [RES_W-1:0]  res_d  [STORE_DEPTH];

    logic              take;
    logic              emit;
    logic              buf_in_ready;
    logic              frame_last;
    tmf_out_s          emit_word;
    logic [INPUT_WIRE_TOTAL-1:0][RES_W-1:0] lane_sum;

    // ---------------- apb slave, one wait state ----------------
    assign wr_access = psel && penable && pready_q && pwrite;

    always_comb begin
        pready_d     = psel && penable && !pready_q;
        pslverr_d    = 1'b0;
        prdata_d     = prdata_q;
        enable_d     = enable_q;
        flush_d      = 1'b0;
        clr_mismatch = 1'b0;
        if (psel && penable && !pready_q) begin
            prdata_d = '0;
            unique case (paddr)
                CTRL_ADDR: begin
                    prdata_d[CTRL_ENABLE_BIT] = enable_q;
                end
                STATUS_ADDR: begin
                    prdata_d[STAT_ENABLE_BIT]   = enable_q;
                    prdata_d[STAT_BUSY_BIT]     = (seq_q == SEQ_EMIT);
                    prdata_d[STAT_MISMATCH_BIT] = mismatch_q;
                end
                CONFIG_ADDR: begin
                    prdata_d[CFG_CHAN_LSB +: CFG_BYTE_W]  = CFG_BYTE_W'(CHANNEL_TOTAL);
                    prdata_d[CFG_IWIRE_LSB +: CFG_NIB_W]  = CFG_NIB_W'(INPUT_WIRE_TOTAL);
                    prdata_d[CFG_OWIRE_LSB +: CFG_NIB_W]  = CFG_NIB_W'(OUTPUT_WIRE_TOTAL);
                    prdata_d[CFG_CPI_LSB +: CFG_NIB_W]    =
                        CFG_NIB_W'(CHANNELS_PER_INPUT_WIRE);
                    prdata_d[CFG_CPO_LSB +: CFG_NIB_W]    =
                        CFG_NIB_W'(CHANNELS_PER_OUTPUT_WIRE);
                    prdata_d[CFG_FOLD_LSB +: CFG_BYTE_W]  = CFG_BYTE_W'(FOLD);
                end
                FRAMES_ADDR: begin
                    prdata_d = frames_q;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        // writes land on the completing edge only
        if (wr_access) begin
            if (paddr == CTRL_ADDR) begin
                enable_d = pwdata[CTRL_ENABLE_BIT];
                flush_d  = pwdata[CTRL_FLUSH_BIT];
            end
            if (paddr == STATUS_ADDR) begin
                clr_mismatch = pwdata[STAT_MISMATCH_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            enable_q  <= CTRL_ENABLE_RST;
            flush_q   <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
            enable_q  <= enable_d;
            flush_q   <= flush_d;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    // ---------------- shared datapath, one per input wire ----------------
    // each lane is a 2-tap sum reused across every slot of its wire
    for (genvar w = 0; w < INPUT_WIRE_TOTAL; w++) begin : g_lane
        localparam int BASE = w * CHANNELS_PER_INPUT_WIRE;
        logic [DATA_W-1:0] prev;
        always_comb begin
            prev = '0;
            for (int s = 0; s < CHANNELS_PER_INPUT_WIRE; s++) begin
                if (islot_q == CHAN_W'(s)) begin
                    prev = hist_q[BASE + s];
                end
            end
        end
        assign lane_sum[w] = RES_W'(in_word.data[w]) + RES_W'(prev);
    end

    // ---------------- serializer in, deserializer out ----------------
    assign take = in_valid && in_ready_q;
    assign emit = (seq_q == SEQ_EMIT);

    always_comb begin
        islot_d    = islot_q;
        oslot_d    = oslot_q;
        keep_d     = keep_q;
        seq_d      = seq_q;
        hist_d     = hist_q;
        res_d      = res_q;
        if (take) begin
            for (int w = 0; w < INPUT_WIRE_TOTAL; w++) begin
                hist_d[w * CHANNELS_PER_INPUT_WIRE + int'(islot_q)] = in_word.data[w];
                if (keep_q) begin
                    res_d[w * CHANNELS_PER_INPUT_WIRE + int'(islot_q)] = lane_sum[w];
                end
            end
            if (islot_q == CHAN_W'(CHANNELS_PER_INPUT_WIRE - 1)) begin
                islot_d = '0;
                keep_d  = !keep_q;
                if (keep_q) begin
                    seq_d   = SEQ_EMIT;
                    oslot_d = '0;
                end
            end else begin
                islot_d = islot_q + 1'b1;
            end
        end
        if (emit && buf_in_ready) begin
            if (oslot_q == CHAN_W'(CHANNELS_PER_OUTPUT_WIRE - 1)) begin
                seq_d    = SEQ_IDLE;
            end else begin
                oslot_d = oslot_q + 1'b1;
            end
        end
        if (flush_q) begin
            islot_d = '0;
            keep_d  = 1'b0;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                hist_d[i] = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            islot_q    <= '0;
            oslot_q    <= '0;
            keep_q     <= 1'b0;
            seq_q      <= SEQ_IDLE;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                hist_q[i] <= '0;
                res_q[i]  <= '0;
            end
        end else begin
            islot_q    <= islot_d;
            oslot_q    <= oslot_d;
            keep_q     <= keep_d;
            seq_q      <= seq_d;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                hist_q[i] <= hist_d[i];
                res_q[i]  <= res_d[i];
            end
        end
    end

    // ---------------- source back-pressure ----------------
    // hold off the source rather than overwrite results still leaving
    // decided from next-state values so the registered ready does not lag a frame end
    always_comb begin
        in_ready_d = enable_d && !(keep_d && seq_d == SEQ_EMIT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_ready_q <= 1'b0;
        end else begin
            in_ready_q <= in_ready_d;
        end
    end

    assign in_ready = in_ready_q;

    // ---------------- sticky source-index mismatch ----------------
    always_comb begin
        mismatch_d = mismatch_q;
        if (clr_mismatch) begin
            mismatch_d = 1'b0;
        end
        // only taken words are compared: the index is a don't-care while valid is low
        // placed after the clear so a same-cycle set wins
        if (take && in_word.channel != islot_q) begin
            mismatch_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch_d;
        end
    end

    // ---------------- emitted frame counter ----------------
    // counts frames handed to the buffer, not frames the consumer has taken
    assign frame_last = emit && buf_in_ready
        && oslot_q == CHAN_W'(CHANNELS_PER_OUTPUT_WIRE - 1);

    always_comb begin
        frames_d = frames_q;
        if (frame_last) begin
            frames_d = frames_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_q <= '0;
        end else begin
            frames_q <= frames_d;
        end
    end

    // output word: channel o*cpo+slot sits on wire o at slot position
    always_comb begin
        emit_word.channel = oslot_q;
        for (int o = 0; o < OUTPUT_WIRE_TOTAL; o++) begin
            emit_word.data[o] =
                res_q[o * CHANNELS_PER_OUTPUT_WIRE + int'(oslot_q)];
        end
    end

    tmf_buf #(
        .WIDTH ($bits(tmf_out_s))
    ) u_buf (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (emit),
        .in_ready  (buf_in_ready),
        .in_data   (emit_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );
endmodule
`default_nettype wire

// ==== tb/tmf_sched_checker.sv ====
// checker bound to the scheduler ports
`default_nettype none
module tmf_sched_checker
    import tmf_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire tmf_out_s          out_word
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [CHAN_W-1:0] och_q, och_d;
    logic              map_ok;
    assign map_ok = paddr inside {CTRL_ADDR, STATUS_ADDR, CONFIG_ADDR, FRAMES_ADDR};
    always_comb begin
        och_d = och_q;
        if (out_valid && out_ready) och_d = och_q + 1'b1;
    end
    // single output wire: index wraps with the two-bit field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) och_q <= '0;
        else och_q <= och_d;
    end
    chk_pready_late: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_map: assert property (pready |-> pslverr == !map_ok)
        else $error("slave error disagrees with address map");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_cfg_layout: assert property (pready && !pwrite && paddr == CONFIG_ADDR
        |-> prdata == 32'h03421204) else $error("layout word wrong");
    chk_ctrl_rsvd: assert property (pready && !pwrite && paddr == CTRL_ADDR
        |-> prdata[31:1] == 31'h0) else $error("control upper bits not zero");
    chk_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("stalled output word changed");
    chk_out_order: assert property (out_valid |-> out_word.channel == och_q)
        else $error("output index out of order");
    chk_out_burst: assert property (
        out_valid && out_ready && out_word.channel != 2'd3 |=> out_valid)
        else $error("gap inside output frame");
    cov_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
    cov_refuse: cover property (pready && pslverr);
    cov_frame_end: cover property (out_valid && out_ready && out_word.channel == 2'd3);
endmodule
bind tmf_sched tmf_sched_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
);
`default_nettype wire

// ==== tb/tmf_far.sv ====
// upstream frame source and downstream consumer for the scheduler
`default_nettype none
module tmf_far
    import tmf_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       bad,
    input  wire logic [1:0] mode,
    input  wire logic       in_ready,
    output var  logic       in_valid,
    output var  tmf_in_s    in_word,
    output var  logic       out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph;
    logic [5:0] fr;
    logic [1:0] cnt;
    initial begin
        in_valid = 1'b0;
        in_word = '0;
        out_ready = 1'b0;
        ph = 2'd0;
        fr = '0;
        cnt = '0;
    end
    // frame of three slots: two channels per wire, then one idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            ph       <= 2'd0;
        end else if (!in_valid || in_ready) begin
            if (ph == 2'd2 || (ph == 2'd0 && !run)) begin
                in_valid <= 1'b0;
                in_word  <= ~in_word;
                ph       <= 2'd0;
            end else begin
                in_valid        <= 1'b1;
                in_word.channel <= CHAN_W'(ph) ^ CHAN_W'(bad);
                in_word.data[0] <= 8'(fr * 4 + ph + 1);
                in_word.data[1] <= 8'(fr * 4 + ph + 3);
                ph              <= ph + 2'd1;
                fr              <= fr + 6'(ph);
            end
        end
    end
    // mode 0 always ready, 1 two on two off, 2 blocked
    always @(posedge pclk) begin
        cnt       <= cnt + 2'd1;
        out_ready <= (mode == 2'd0) || (mode == 2'd1 && cnt[1]);
    end
endmodule
`default_nettype wire

// ==== tb/tmf_sched_tb.sv ====
// scheduler testbench: register checks and framed traffic
`default_nettype none
module tmf_sched_tb
    import tmf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              pclk = 1'b0, presetn = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata;
    logic              pready, pslverr, in_valid, in_ready, out_valid, out_ready;
    logic              run = 1'b0, bad = 1'b0, islot = 1'b0;
    logic [1:0]        far_mode = 2'd0;
    tmf_in_s           in_word;
    tmf_out_s          out_word;
    logic [7:0]        cur [4];
    logic [7:0]        prev [4];
    logic [RES_W-1:0]  expq [$];
    logic [RES_W-1:0]  ex;
    int                fidx = 0, ocnt = 0, cyc = 0, err_count = 0, checked = 0;

    always #50 pclk = ~pclk;

    tmf_sched u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
    tmf_far u_far (.pclk(pclk), .presetn(presetn), .run(run), .bad(bad), .mode(far_mode),
        .in_ready(in_ready), .in_valid(in_valid), .in_word(in_word), .out_ready(out_ready));

    task automatic results();
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
        checked++;
        if (got !== exv) begin
            $display("[ERR] %s expected %h seen %h", nm, exv, got);
            err_count++;
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // reference: every second frame summed with the frame before it
    always @(posedge pclk) begin
        if (presetn && in_valid && in_ready) begin
            cur[islot] = in_word.data[0];
            cur[islot + 2] = in_word.data[1];
            if (islot) begin
                for (int i = 0; i < 4 && fidx % 2 == 1; i++)
                    expq.push_back(RES_W'(cur[i]) + RES_W'(prev[i]));
                prev = cur;
                fidx++;
            end
            islot = !islot;
        end
        if (presetn && out_valid && out_ready) begin
            ex = (expq.size() != 0) ? expq.pop_front() : '1;
            chk("out_chan", 32'(ocnt % 4), 32'(out_word.channel));
            chk("out_data", 32'(ex), 32'(out_word.data[0]));
            ocnt++;
        end
    end

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(CONFIG_ADDR, 1'b0, 32'h0, r, e);
        chk("config", 32'h03421204, r);
        apb(CONFIG_ADDR, 1'b1, 32'hFFFFFFFF, r, e);
        apb(CONFIG_ADDR, 1'b0, 32'h0, r, e);
        chk("config_ro", 32'h03421204, r);
        apb(8'h10, 1'b0, 32'h0, r, e);
        chk("unmapped_err", 32'h1, 32'(e));
        apb(CTRL_ADDR, 1'b0, 32'h0, r, e);
        chk("ctrl_reset", 32'h1, r);
    endtask

    task automatic t_stream(input logic [1:0] m);
        int          n;
        logic [31:0] r;
        logic        e;
        far_mode <= m;
        run <= 1'b1;
        repeat (30) @(posedge pclk);
        if (m == 2'd2) begin
            chk("in_ready_held", 32'h0, 32'(in_ready));
            apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
            chk("busy_stalled", 32'h1, 32'(r[STAT_BUSY_BIT]));
            far_mode <= 2'd0;
        end
        run <= 1'b0;
        n = 0;
        while ((expq.size() != 0 || in_valid) && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk("drained", 32'h0, 32'(expq.size()));
    endtask

    task automatic t_bad();
        logic [31:0] r;
        logic        e;
        apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
        chk("mismatch_clean", 32'h0, 32'(r[STAT_MISMATCH_BIT]));
        bad <= 1'b1;
        t_stream(2'd0);
        bad <= 1'b0;
        apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
        chk("mismatch_set", 32'h1, 32'(r[STAT_MISMATCH_BIT]));
        apb(STATUS_ADDR, 1'b1, 32'h4, r, e);
        apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
        chk("mismatch_clr", 32'h0, 32'(r[STAT_MISMATCH_BIT]));
    endtask

    task automatic t_off();
        logic [31:0] r;
        logic        e;
        apb(FRAMES_ADDR, 1'b0, 32'h0, r, e);
        chk("frames", 32'(ocnt / 4), r);
        apb(CTRL_ADDR, 1'b1, 32'h0, r, e);
        apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
        chk("enable_off", 32'h0, 32'(r[STAT_ENABLE_BIT]));
        chk("in_ready_off", 32'h0, 32'(in_ready));
        // re-enable with flush: slot and decimation phase restart at frame zero
        apb(CTRL_ADDR, 1'b1, 32'h3, r, e);
        fidx = 0;
        islot = 1'b0;
        t_stream(2'd0);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_stream(2'd0);
        t_stream(2'd1);
        t_stream(2'd2);
        t_bad();
        t_off();
        results();
    end
endmodule
`default_nettype wire
